/* verilog/param_store_map.vh */
// Purpose: constants of the parameter store and update control
// Assumes: included by the parameter store design files
// Notes: definitions only
`ifndef PARAM_STORE_MAP_VH
`define PARAM_STORE_MAP_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define PS_COUNT 64
`define PS_AW 6
`define PS_DW 16
`define PS_LAST_IDX 6'h3F

// ----------------------------------------
// Update classes
// ----------------------------------------
`define PS_CLS_W 2
`define PS_CLS_A 2'h0
`define PS_CLS_B 2'h1
`define PS_CLS_C 2'h2
`define PS_CLS_D 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PS_IDX_RST 6'h00
`define PS_DATA_RST 16'h0000

`endif

/* verilog/param_nvm_port.v */
// Purpose: single-word access sequencer toward the non-volatile store
// Assumes: store answers with a one-cycle ack on the system clock
// Notes: one access at a time; start is ignored while busy
`timescale 1ns/1ps
`include "param_store_map.vh"

module param_nvm_port (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire we_i,
  input wire [`PS_AW-1:0] addr_i,
  input wire [`PS_DW-1:0] wdata_i,
  input wire ack_i,
  input wire [`PS_DW-1:0] rdata_i,
  output reg req_o,
  output reg we_o,
  output reg [`PS_AW-1:0] addr_o,
  output reg [`PS_DW-1:0] wdata_o,
  output reg done_o,
  output reg [`PS_DW-1:0] rdata_o
);

  // ----------------------------------------
  // Request held until acknowledged
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      req_o <= 1'b0;
      we_o <= 1'b0;
      addr_o <= `PS_IDX_RST;
      wdata_o <= `PS_DATA_RST;
      done_o <= 1'b0;
      rdata_o <= `PS_DATA_RST;
    end else begin
      done_o <= 1'b0;
      if (req_o) begin
        if (ack_i) begin
          req_o <= 1'b0;
          we_o <= 1'b0;
          done_o <= 1'b1;
          rdata_o <= rdata_i;
        end
      end else if (start_i) begin
        req_o <= 1'b1;
        we_o <= we_i;
        addr_o <= addr_i;
        wdata_o <= wdata_i;
      end
    end
  end

endmodule

/* verilog/parameter_store_update_control.v */
// Purpose: working copy, persistent copy and update timing of drive parameters
// Assumes: all inputs come from logic on CLK_SYS_I; SYS_RST_I is the power-up reset
// Notes: persistent store is external and reached through NVM_* ports
//
// Behaviour
// - Working copy is not kept over power loss; reset reloads it fully.
// - Persistent store is only written by commit or tool writes.
// - At power-up every parameter is copied from persistent store to working copy.
// - After that copy all applied values are recomputed from the working copy.
// - Bus or network writes change only the working copy.
// - Commit command copies every working parameter into the persistent store.
// - Configuration tool writes go straight into the persistent store.
// - Class A values are applied in the cycle the write is taken.
// - Class B values are applied once motion has stopped.
// - Class C values are applied on configuration command or power cycle.
// - Class D values are applied only after a power cycle.
`timescale 1ns/1ps
`include "param_store_map.vh"

module parameter_store_update_control (
  input wire CLK_SYS_I,
  input wire SYS_RST_I,
  input wire WR_VALID_I,
  input wire [`PS_AW-1:0] WR_ADDR_I,
  input wire [`PS_DW-1:0] WR_DATA_I,
  input wire [`PS_CLS_W-1:0] WR_CLASS_I,
  output reg WR_READY_O,
  input wire COMMIT_I,
  input wire CONFIG_I,
  input wire MOTION_STOPPED_I,
  input wire TOOL_VALID_I,
  input wire [`PS_AW-1:0] TOOL_ADDR_I,
  input wire [`PS_DW-1:0] TOOL_DATA_I,
  output reg TOOL_READY_O,
  input wire [`PS_AW-1:0] RD_ADDR_I,
  output reg [`PS_DW-1:0] APPLIED_DATA_O,
  output reg PENDING_O,
  output reg PARAM_READY_O,
  output reg APPLY_STROBE_O,
  output reg [`PS_AW-1:0] APPLY_ADDR_O,
  output wire NVM_REQ_O,
  output wire NVM_WE_O,
  output wire [`PS_AW-1:0] NVM_ADDR_O,
  output wire [`PS_DW-1:0] NVM_WDATA_O,
  input wire NVM_ACK_I,
  input wire [`PS_DW-1:0] NVM_RDATA_I
);

  localparam [2:0] ST_LOAD = 3'h0;
  localparam [2:0] ST_LOADW = 3'h1;
  localparam [2:0] ST_APPLY = 3'h2;
  localparam [2:0] ST_IDLE = 3'h3;
  localparam [2:0] ST_COMMIT = 3'h4;
  localparam [2:0] ST_COMMITW = 3'h5;
  localparam [2:0] ST_TOOLW = 3'h6;
  localparam [2:0] ST_SCAN = 3'h7;

  reg [`PS_DW-1:0] ram_q [0:`PS_COUNT-1];
  reg [`PS_DW-1:0] applied_q [0:`PS_COUNT-1];
  reg [`PS_COUNT-1:0] pend_q;
  reg [`PS_CLS_W-1:0] cls_q [0:`PS_COUNT-1];

  reg [2:0] state_q, state_d;
  reg [`PS_AW-1:0] idx_q, idx_d;
  reg scan_b_q, scan_b_d;
  reg b_wait_q, c_wait_q, commit_q, cfg_wait_q;

  reg ram_we, app_we, pend_we, pend_wv, nvm_start, nvm_we;
  reg [`PS_AW-1:0] ram_wa, app_wa, nvm_addr;
  reg [`PS_DW-1:0] ram_wd, app_wd, nvm_wdata;
  reg [`PS_CLS_W-1:0] pend_wc;
  reg take_wr, take_tool, start_b, start_c, start_commit, scan_hit;
  wire nvm_done;
  wire [`PS_DW-1:0] nvm_rdata;

  param_nvm_port u_nvm (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .start_i(nvm_start),
    .we_i(nvm_we),
    .addr_i(nvm_addr),
    .wdata_i(nvm_wdata),
    .ack_i(NVM_ACK_I),
    .rdata_i(NVM_RDATA_I),
    .req_o(NVM_REQ_O),
    .we_o(NVM_WE_O),
    .addr_o(NVM_ADDR_O),
    .wdata_o(NVM_WDATA_O),
    .done_o(nvm_done),
    .rdata_o(nvm_rdata)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    idx_d = idx_q;
    scan_b_d = scan_b_q;
    ram_we = 1'b0;
    ram_wa = idx_q;
    ram_wd = nvm_rdata;
    app_we = 1'b0;
    app_wa = idx_q;
    app_wd = ram_q[idx_q];
    pend_we = 1'b0;
    pend_wv = 1'b0;
    pend_wc = cls_q[idx_q];
    nvm_start = 1'b0;
    nvm_we = 1'b0;
    nvm_addr = idx_q;
    nvm_wdata = ram_q[idx_q];
    take_wr = 1'b0;
    take_tool = 1'b0;
    start_b = 1'b0;
    start_c = 1'b0;
    start_commit = 1'b0;
    scan_hit = pend_q[idx_q] &&
      ((scan_b_q && cls_q[idx_q] == `PS_CLS_B) ||
       (!scan_b_q && cls_q[idx_q] == `PS_CLS_C));
    case (state_q)
      ST_LOAD: begin
        nvm_start = 1'b1;
        state_d = ST_LOADW;
      end
      ST_LOADW: begin
        if (nvm_done) begin
          ram_we = 1'b1;
          if (idx_q == `PS_LAST_IDX) begin
            idx_d = `PS_IDX_RST;
            state_d = ST_APPLY;
          end else begin
            idx_d = idx_q + 6'h01;
            state_d = ST_LOAD;
          end
        end
      end
      ST_APPLY: begin
        app_we = 1'b1;
        pend_we = 1'b1;
        if (idx_q == `PS_LAST_IDX) begin
          idx_d = `PS_IDX_RST;
          state_d = ST_IDLE;
        end else begin
          idx_d = idx_q + 6'h01;
        end
      end
      ST_IDLE: begin
        if (commit_q) begin
          start_commit = 1'b1;
          idx_d = `PS_IDX_RST;
          state_d = ST_COMMIT;
        end else if (TOOL_VALID_I && TOOL_READY_O) begin
          take_tool = 1'b1;
          nvm_start = 1'b1;
          nvm_we = 1'b1;
          nvm_addr = TOOL_ADDR_I;
          nvm_wdata = TOOL_DATA_I;
          state_d = ST_TOOLW;
        end else if (WR_VALID_I && WR_READY_O) begin
          // A shown ready is honoured before any deferred pass
          take_wr = 1'b1;
          ram_we = 1'b1;
          ram_wa = WR_ADDR_I;
          ram_wd = WR_DATA_I;
          pend_we = 1'b1;
          pend_wc = WR_CLASS_I;
          app_wa = WR_ADDR_I;
          app_wd = WR_DATA_I;
          if (WR_CLASS_I == `PS_CLS_A) begin
            app_we = 1'b1;
          end else begin
            pend_wv = 1'b1;
          end
        end else if (b_wait_q && MOTION_STOPPED_I) begin
          start_b = 1'b1;
          scan_b_d = 1'b1;
          idx_d = `PS_IDX_RST;
          state_d = ST_SCAN;
        end else if (cfg_wait_q && c_wait_q) begin
          start_c = 1'b1;
          scan_b_d = 1'b0;
          idx_d = `PS_IDX_RST;
          state_d = ST_SCAN;
        end
      end
      ST_COMMIT: begin
        nvm_start = 1'b1;
        nvm_we = 1'b1;
        state_d = ST_COMMITW;
      end
      ST_COMMITW: begin
        if (nvm_done) begin
          if (idx_q == `PS_LAST_IDX) begin
            idx_d = `PS_IDX_RST;
            state_d = ST_IDLE;
          end else begin
            idx_d = idx_q + 6'h01;
            state_d = ST_COMMIT;
          end
        end
      end
      ST_TOOLW: begin
        if (nvm_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_SCAN: begin
        if (scan_hit) begin
          app_we = 1'b1;
          pend_we = 1'b1;
        end
        if (idx_q == `PS_LAST_IDX) begin
          idx_d = `PS_IDX_RST;
          state_d = ST_IDLE;
        end else begin
          idx_d = idx_q + 6'h01;
        end
      end
      default: begin
        state_d = ST_LOAD;
      end
    endcase
  end

  // ----------------------------------------
  // Parameter arrays
  // ----------------------------------------
  always @(posedge CLK_SYS_I) begin
    if (ram_we) begin
      ram_q[ram_wa] <= ram_wd;
    end
    if (app_we) begin
      applied_q[app_wa] <= app_wd;
    end
    if (pend_we) begin
      cls_q[app_wa] <= pend_wc;
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      pend_q <= {`PS_COUNT{1'b0}};
    end else if (pend_we) begin
      pend_q[app_wa] <= pend_wv;
    end
  end

  // ----------------------------------------
  // Control state and outputs
  // ----------------------------------------
  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      state_q <= ST_LOAD;
      idx_q <= `PS_IDX_RST;
      scan_b_q <= 1'b0;
      b_wait_q <= 1'b0;
      c_wait_q <= 1'b0;
      cfg_wait_q <= 1'b0;
      commit_q <= 1'b0;
      WR_READY_O <= 1'b0;
      TOOL_READY_O <= 1'b0;
      APPLIED_DATA_O <= `PS_DATA_RST;
      PENDING_O <= 1'b0;
      PARAM_READY_O <= 1'b0;
      APPLY_STROBE_O <= 1'b0;
      APPLY_ADDR_O <= `PS_IDX_RST;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      scan_b_q <= scan_b_d;
      // Event latches: a new set wins over the clear of a starting pass
      commit_q <= COMMIT_I || (commit_q && !start_commit);
      cfg_wait_q <= CONFIG_I || (cfg_wait_q && c_wait_q && !start_c);
      b_wait_q <= (take_wr && WR_CLASS_I == `PS_CLS_B) || (b_wait_q && !start_b);
      c_wait_q <= (take_wr && WR_CLASS_I == `PS_CLS_C) || (c_wait_q && !start_c);
      // Ready stays low while a commit is latched, so a shown write ready is refused only when a tool write is taken in the same cycle
      WR_READY_O <= (state_d == ST_IDLE) && !take_wr && !take_tool && !COMMIT_I && !commit_q;
      TOOL_READY_O <= (state_d == ST_IDLE) && !take_wr && !take_tool && !COMMIT_I && !commit_q;
      APPLIED_DATA_O <= applied_q[RD_ADDR_I];
      PENDING_O <= pend_q[RD_ADDR_I];
      PARAM_READY_O <= (state_q == ST_APPLY && idx_q == `PS_LAST_IDX) || PARAM_READY_O;
      APPLY_STROBE_O <= app_we;
      APPLY_ADDR_O <= app_wa;
    end
  end

endmodule

/* bench/param_nvm_model.sv */
// Purpose: behavioural non-volatile parameter store
// Assumes: same clock as the block; lat_i sets answer delay
// Notes: contents survive block reset
`timescale 1ns/1ps
module param_nvm_model (
  input wire clk_i,
  input wire [3:0] lat_i,
  input wire req_i,
  input wire we_i,
  input wire [5:0] addr_i,
  input wire [15:0] wdata_i,
  output logic ack_o,
  output wire [15:0] rdata_o
);
  logic [15:0] mem [0:63];
  logic [15:0] q;
  logic [3:0] n;
  int writes;
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'hA000 | 16'(i);
    end
    ack_o = 1'b0;
    q = 16'h0000;
    n = 4'h0;
    writes = 0;
  end
  // Idle data shows the inverse of the last word
  assign rdata_o = ack_o ? q : ~q;
  // No reset: contents kept over power loss
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    if (!req_i || ack_o) begin
      n <= 4'h0;
    end else if (n < lat_i) begin
      n <= n + 4'h1;
    end else begin
      ack_o <= 1'b1;
      q <= mem[addr_i];
      if (we_i) begin
        mem[addr_i] <= wdata_i;
        writes <= writes + 1;
      end
    end
  end
endmodule

/* bench/param_store_sva.sv */
// Purpose: port checks of the parameter store
// Assumes: single clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
`include "param_store_map.vh"
module param_store_sva (
  input wire CLK_SYS_I,
  input wire SYS_RST_I,
  input wire WR_VALID_I,
  input wire [5:0] WR_ADDR_I,
  input wire [1:0] WR_CLASS_I,
  input wire WR_READY_O,
  input wire COMMIT_I,
  input wire TOOL_VALID_I,
  input wire TOOL_READY_O,
  input wire PARAM_READY_O,
  input wire APPLY_STROBE_O,
  input wire [5:0] APPLY_ADDR_O,
  input wire NVM_REQ_O,
  input wire NVM_WE_O,
  input wire [5:0] NVM_ADDR_O,
  input wire [15:0] NVM_WDATA_O,
  input wire NVM_ACK_I
);
  logic [6:0] strobes_q;
  logic [6:0] reads_q;
  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      strobes_q <= 7'h00;
      reads_q <= 7'h00;
    end else begin
      if (APPLY_STROBE_O && !PARAM_READY_O) strobes_q <= strobes_q + 7'h01;
      if (NVM_ACK_I && NVM_REQ_O && !NVM_WE_O) reads_q <= reads_q + 7'h01;
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  sequence taken;
    WR_VALID_I && WR_READY_O && !TOOL_VALID_I && !COMMIT_I;
  endsequence
  load_count_a: assert property ($rose(PARAM_READY_O) |-> reads_q == 7'h40 &&
    strobes_q + {6'h00, APPLY_STROBE_O} == 7'h40) else $error("load count wrong");
  ready_gate_a: assert property (!PARAM_READY_O |-> !WR_READY_O)
    else $error("write open before load");
  ready_sticky_a: assert property (PARAM_READY_O |=> PARAM_READY_O)
    else $error("param ready dropped");
  ready_pair_a: assert property (WR_READY_O == TOOL_READY_O)
    else $error("ready flags differ");
  class_a_apply_a: assert property (taken ##0 WR_CLASS_I == `PS_CLS_A |=>
    APPLY_STROBE_O && APPLY_ADDR_O == $past(WR_ADDR_I)) else $error("class A not applied");
  defer_hold_a: assert property (taken ##0 WR_CLASS_I != `PS_CLS_A |=>
    !APPLY_STROBE_O) else $error("deferred value applied");
  ram_only_a: assert property (taken |=> !(NVM_REQ_O && NVM_WE_O) [*2])
    else $error("bus write reached store");
  req_hold_a: assert property (NVM_REQ_O && !NVM_ACK_I |=> NVM_REQ_O &&
    $stable(NVM_ADDR_O) && $stable(NVM_WE_O) && $stable(NVM_WDATA_O))
    else $error("store request moved");
  req_drop_a: assert property (NVM_REQ_O && NVM_ACK_I |=> !NVM_REQ_O)
    else $error("store request held past ack");
  no_early_write_a: assert property (!PARAM_READY_O |-> !(NVM_REQ_O && NVM_WE_O))
    else $error("store written during load");
endmodule
bind parameter_store_update_control param_store_sva param_store_sva_inst (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .WR_VALID_I(WR_VALID_I),
  .WR_ADDR_I(WR_ADDR_I), .WR_CLASS_I(WR_CLASS_I), .WR_READY_O(WR_READY_O),
  .COMMIT_I(COMMIT_I), .TOOL_VALID_I(TOOL_VALID_I), .TOOL_READY_O(TOOL_READY_O),
  .PARAM_READY_O(PARAM_READY_O), .APPLY_STROBE_O(APPLY_STROBE_O),
  .APPLY_ADDR_O(APPLY_ADDR_O), .NVM_REQ_O(NVM_REQ_O), .NVM_WE_O(NVM_WE_O),
  .NVM_ADDR_O(NVM_ADDR_O), .NVM_WDATA_O(NVM_WDATA_O), .NVM_ACK_I(NVM_ACK_I));

/* bench/parameter_store_update_control_tb_top.sv */
// Purpose: self-checking bench of the parameter store
// Assumes: inputs change at the falling edge
// Notes: store is the behavioural model
`timescale 1ns/1ps
`include "param_store_map.vh"
module parameter_store_update_control_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_valid = 1'b0;
  logic commit = 1'b0;
  logic cfg = 1'b0;
  logic stopped = 1'b0;
  logic tool_valid = 1'b0;
  logic [5:0] wr_addr = 6'h00;
  logic [5:0] tool_addr = 6'h00;
  logic [5:0] rd_addr = 6'h00;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] tool_data = 16'h0000;
  logic [1:0] wr_class = 2'h0;
  logic [3:0] lat = 4'h0;
  logic wr_ready, tool_ready, pending, param_ready, strobe, nvm_req, nvm_we, nvm_ack;
  logic [15:0] applied, nvm_wdata, nvm_rdata;
  logic [5:0] apply_addr, nvm_addr;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int strobes = 0;
  int n;
  parameter_store_update_control parameter_store_update_control_inst (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .WR_VALID_I(wr_valid), .WR_ADDR_I(wr_addr),
    .WR_DATA_I(wr_data), .WR_CLASS_I(wr_class), .WR_READY_O(wr_ready),
    .COMMIT_I(commit), .CONFIG_I(cfg), .MOTION_STOPPED_I(stopped),
    .TOOL_VALID_I(tool_valid), .TOOL_ADDR_I(tool_addr), .TOOL_DATA_I(tool_data),
    .TOOL_READY_O(tool_ready), .RD_ADDR_I(rd_addr), .APPLIED_DATA_O(applied),
    .PENDING_O(pending), .PARAM_READY_O(param_ready), .APPLY_STROBE_O(strobe),
    .APPLY_ADDR_O(apply_addr), .NVM_REQ_O(nvm_req), .NVM_WE_O(nvm_we),
    .NVM_ADDR_O(nvm_addr), .NVM_WDATA_O(nvm_wdata), .NVM_ACK_I(nvm_ack),
    .NVM_RDATA_I(nvm_rdata));
  param_nvm_model param_nvm_model_inst (.clk_i(clk), .lat_i(lat), .req_i(nvm_req),
    .we_i(nvm_we), .addr_i(nvm_addr), .wdata_i(nvm_wdata), .ack_o(nvm_ack),
    .rdata_o(nvm_rdata));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (strobe === 1'b1) strobes++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wait_lvl(input logic v);
    for (int i = 0; i < 2000 && wr_ready !== v; i++) @(negedge clk);
  endtask
  task automatic bus_write(input logic [5:0] a, input logic [15:0] d, input logic [1:0] c);
    @(negedge clk);
    {wr_addr, wr_data, wr_class, wr_valid} = {a, d, c, 1'b1};
    wait_lvl(1'b1);
    @(negedge clk);
    wr_valid = 1'b0;
  endtask
  task automatic read_chk(input logic [5:0] a, input logic [15:0] e, input logic p);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    chk_val(applied, e);
    chk_bit(pending, p);
  endtask
  task automatic power_cycle;
    @(negedge clk);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    wait_lvl(1'b1);
  endtask
  task automatic t_powerup;
    power_cycle;
    chk_bit(param_ready, 1'b1);
    read_chk(6'h00, 16'hA000, 1'b0);
    read_chk(6'h3F, 16'hA03F, 1'b0);
    $display("test powerup done");
  endtask
  task automatic t_class_a;
    bus_write(6'h05, 16'h1234, `PS_CLS_A);
    read_chk(6'h05, 16'h1234, 1'b0);
    chk_val(param_nvm_model_inst.mem[5], 16'hA005);
    $display("test class_a done");
  endtask
  task automatic t_deferred;
    bus_write(6'h06, 16'hBBBB, `PS_CLS_B);
    bus_write(6'h07, 16'hCCCC, `PS_CLS_C);
    bus_write(6'h08, 16'hDDDD, `PS_CLS_D);
    read_chk(6'h06, 16'hA006, 1'b1);
    n = strobes;
    stopped = 1'b1;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    read_chk(6'h06, 16'hBBBB, 1'b0);
    chk_val(16'(strobes - n), 16'h0001);
    read_chk(6'h07, 16'hA007, 1'b1);
    cfg = 1'b1;
    @(negedge clk);
    cfg = 1'b0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    read_chk(6'h07, 16'hCCCC, 1'b0);
    read_chk(6'h08, 16'hA008, 1'b1);
    $display("test deferred done");
  endtask
  task automatic t_commit;
    lat = 4'h3;
    n = param_nvm_model_inst.writes;
    commit = 1'b1;
    @(negedge clk);
    commit = 1'b0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    lat = 4'h0;
    chk_val(16'(param_nvm_model_inst.writes - n), 16'h0040);
    chk_val(param_nvm_model_inst.mem[5], 16'h1234);
    chk_val(param_nvm_model_inst.mem[8], 16'hDDDD);
    $display("test commit done");
  endtask
  task automatic t_tool;
    @(negedge clk);
    {tool_addr, tool_data, tool_valid} = {6'h09, 16'h9999, 1'b1};
    for (int i = 0; i < 2000 && tool_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    tool_valid = 1'b0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk_val(param_nvm_model_inst.mem[9], 16'h9999);
    read_chk(6'h09, 16'hA009, 1'b0);
    $display("test tool done");
  endtask
  task automatic t_power;
    bus_write(6'h0A, 16'h5555, `PS_CLS_A);
    power_cycle;
    read_chk(6'h08, 16'hDDDD, 1'b0);
    read_chk(6'h0A, 16'hA00A, 1'b0);
    read_chk(6'h09, 16'h9999, 1'b0);
    read_chk(6'h05, 16'h1234, 1'b0);
    $display("test power done");
  endtask
  initial begin
    t_powerup;
    t_class_a;
    t_deferred;
    t_commit;
    t_tool;
    t_power;
    tally_and_finish;
  end
endmodule
